// *** core/see_pkg.sv ***
package see_pkg;

    localparam logic [6:0]  DEV_CODE       = 7'h50;
    localparam int unsigned MEM_BYTES      = 256;
    localparam logic [7:0]  ERASED         = 8'hff;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [3:0]  ACK_BIT        = 4'h8;

    localparam int unsigned CORE_CLK_MHZ   = 250;
    localparam int unsigned SCL_KHZ        = 100;
    localparam int unsigned SCL_QTR_CYC    = CORE_CLK_MHZ * 1000 / (4 * SCL_KHZ);
    localparam int unsigned T_PROG_MS      = 10;
    localparam int unsigned T_PROG_LONG_MS = 20;
    localparam int unsigned PROG_CYC       = T_PROG_MS * CORE_CLK_MHZ * 1000;
    localparam int unsigned PROG_LONG_CYC  = T_PROG_LONG_MS * CORE_CLK_MHZ * 1000;

    typedef enum logic [2:0] {
        D_IDLE, D_DEV, D_ADDR, D_WDAT, D_ACK, D_RDAT, D_RACK, D_RNEXT
    } see_dst_e;

    typedef enum logic [1:0] {
        OP_START, OP_STOP, OP_WRITE, OP_READ
    } see_op_e;

    typedef enum logic {
        M_IDLE, M_RUN
    } see_mst_e;

endpackage : see_pkg

// *** core/see_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface see_link_if;
    logic scl;
    logic m_sda_out;
    logic m_sda_oe;
    logic d_sda_out;
    logic d_sda_oe;
    logic sda;

    // Open-drain wire with pull-up: low while any enabled driver pulls low.
    assign sda = (m_sda_oe ? m_sda_out : 1'b1) & (d_sda_oe ? d_sda_out : 1'b1);

    modport master (output scl, output m_sda_out, output m_sda_oe, input sda);
    modport dev    (input scl, input sda, output d_sda_out, output d_sda_oe);
endinterface : see_link_if

`default_nettype wire

// *** core/see_bus_master.sv ***
`timescale 1ns/100ps
`default_nettype none

module see_bus_master #(
    parameter int unsigned QTR_CYCLES = see_pkg::SCL_QTR_CYC
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             cmd_valid,
    input  wire see_pkg::see_op_e cmd_op,
    input  wire logic [7:0]       cmd_data,
    input  wire logic             cmd_ack,
    output logic                  cmd_ready,
    output logic                  rsp_valid,
    output logic [7:0]            rsp_data,
    output logic                  rsp_ack,
    see_link_if.master            link
);
    import see_pkg::*;

    see_mst_e   st;
    see_op_e    op;
    logic [1:0] sda_sy;
    logic [11:0] qdiv;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic       ack_r;
    logic       scl;
    logic       sda_oe;
    logic       sda_out;

    wire qtick    = (qdiv == 12'(QTR_CYCLES - 1));
    wire is_byte  = (op == OP_WRITE) || (op == OP_READ);
    // The ninth bit releases the line after a write and answers a read as asked.
    wire drv_low  = (bitn == ACK_BIT) ? (op == OP_READ) && ack_r : !sh[7];
    wire last_ph  = (ph == 2'h3) && (!is_byte || bitn == ACK_BIT);

    assign link.scl       = scl;
    assign link.m_sda_oe  = sda_oe;
    assign link.m_sda_out = sda_out;

    always_ff @(posedge core_clk) begin
        sda_sy <= {sda_sy[0], link.sda};
        if (!rst_n) begin
            st        <= M_IDLE;
            op        <= OP_STOP;
            qdiv      <= '0;
            ph        <= '0;
            bitn      <= '0;
            sh        <= '0;
            ack_r     <= 1'b0;
            scl       <= 1'b1;
            sda_oe    <= 1'b0;
            sda_out   <= 1'b0;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
            rsp_ack   <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            qdiv      <= qtick ? '0 : qdiv + 12'h1;
            if (st == M_IDLE) begin
                if (cmd_valid) begin
                    st        <= M_RUN;
                    op        <= cmd_op;
                    ack_r     <= cmd_ack;
                    sh        <= (cmd_op == OP_READ) ? ERASED : cmd_data;
                    bitn      <= '0;
                    ph        <= '0;
                    qdiv      <= '0;
                    cmd_ready <= 1'b0;
                end
            end else if (qtick) begin
                ph <= ph + 2'h1;
                unique case (ph)
                    2'h0: sda_oe <= is_byte ? drv_low : (op == OP_STOP);
                    2'h1: scl <= 1'b1;
                    2'h2: begin
                        if (is_byte && bitn != ACK_BIT) begin
                            sh <= {sh[6:0], sda_sy[1]};
                        end
                        if (is_byte && bitn == ACK_BIT) begin
                            rsp_ack <= !sda_sy[1];
                        end
                        if (!is_byte) begin
                            sda_oe <= (op == OP_START);
                        end
                    end
                    2'h3: begin
                        if (op != OP_STOP) begin
                            scl <= 1'b0;
                        end
                        bitn <= bitn + 4'h1;
                    end
                endcase
                if (last_ph) begin
                    st        <= M_IDLE;
                    cmd_ready <= 1'b1;
                    rsp_valid <= 1'b1;
                    rsp_data  <= sh;
                    if (!is_byte) begin
                        rsp_ack <= 1'b0;
                    end
                end
            end
        end
    end

endmodule : see_bus_master

`default_nettype wire

// *** core/see_eeprom_dev.sv ***
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Mode high multibyte, mode low page write.
// - Write select, then acknowledged 8-bit byte address.
// - Byte write: one acknowledged byte, then STOP.
// - Multibyte: any start address, up to four bytes.
// - Program 10 ms, 20 ms when multibyte rows differ.
// - Multibyte beyond four bytes may corrupt neighbours.
// - Unconnected mode input reads as one.
// - Page write: up to eight bytes, one row.
// - Page write wraps the low three address bits.
// - STOP after write launches program; bus ignored.
// - No select acknowledge while programming.
// - Master polls with START and select.
// - Array starts all ones; reads ignore mode.
// - Read select outputs counter byte, then increments.
// - Master ends single read with NACK, STOP.
// - Random read: dummy write, restart, read.
// - Master acknowledge fetches next incremented byte.
// - Read counter wraps from top to zero.
// - Respond only to select code 1010000.
// - Missing read acknowledge returns to standby.
// - STOP after read returns to standby only.
module see_eeprom_dev #(
    parameter int unsigned PROG_CYCLES      = see_pkg::PROG_CYC,
    parameter int unsigned PROG_LONG_CYCLES = see_pkg::PROG_LONG_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic link_clk,
    input  wire logic mode_drive,
    input  wire logic mode_drive_en,
    output logic      prog_busy,
    see_link_if.dev   link
);
    import see_pkg::*;

    logic [1:0]  lrst;
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic [1:0]  mode_sy;
    see_dst_e    st;
    see_dst_e    ack_next;
    logic [3:0]  cnt;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic [7:0]  addr;
    logic [7:0]  base;
    logic        ack_on;
    logic        wmode;
    logic        span;
    logic        busy;
    logic        req_tgl;
    logic        long_req;
    logic [2:0]  done_sy;
    logic        sda_oe;
    logic        sda_out;
    logic [7:0]  mem     [MEM_BYTES];
    logic [7:0]  wl_data [8];
    logic [7:0]  wl_addr [8];
    logic [7:0]  wl_val;
    logic [2:0]  req_sy;
    logic [1:0]  long_sy;
    logic        done_tgl;
    logic [23:0] pcnt;

    // A floating mode pad is pulled up, which selects multibyte writes.
    wire mode_pad   = mode_drive_en ? mode_drive : 1'b1;
    wire lrst_n     = lrst[1];
    wire sda_in     = sda_sy[1];
    wire scl_rise   = scl_sy[1] && !scl_sy[2];
    wire scl_fall   = !scl_sy[1] && scl_sy[2];
    wire start_cond = scl_sy[1] && scl_sy[2] && !sda_sy[1] && sda_sy[2];
    wire stop_cond  = scl_sy[1] && scl_sy[2] && sda_sy[1] && !sda_sy[2];
    wire rx_state   = (st == D_DEV) || (st == D_ADDR) || (st == D_WDAT);
    wire byte_end   = rx_state && (cnt[2:0] == BIT_LAST);
    wire [7:0] byte_in = {rx[6:0], sda_in};
    wire dev_match  = (byte_in[7:1] == DEV_CODE);
    wire [7:0] next_waddr = wmode ? addr + 8'h1 : {addr[7:3], addr[2:0] + 3'h1};
    wire [7:0] rd_byte = mem[addr];
    wire done_edge  = done_sy[2] ^ done_sy[1];
    wire load_rd    = scl_fall && ((st == D_ACK && ack_on && ack_next == D_RNEXT)
                                   || st == D_RNEXT);

    assign link.d_sda_oe  = sda_oe;
    assign link.d_sda_out = sda_out;

    always_ff @(posedge link_clk) begin
        lrst    <= {lrst[0], rst_n};
        scl_sy  <= {scl_sy[1:0], link.scl};
        sda_sy  <= {sda_sy[1:0], link.sda};
        mode_sy <= {mode_sy[0], mode_pad};
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            st       <= D_IDLE;
            ack_next <= D_IDLE;
            cnt      <= '0;
            rx       <= '0;
            tx       <= '0;
            addr     <= '0;
            base     <= '0;
            ack_on   <= 1'b0;
            wmode    <= 1'b1;
            span     <= 1'b0;
            busy     <= 1'b0;
            req_tgl  <= 1'b0;
            long_req <= 1'b0;
            done_sy  <= '0;
            sda_oe   <= 1'b0;
            sda_out  <= 1'b0;
            wl_val   <= '0;
            for (int i = 0; i < 8; i++) begin
                wl_data[i] <= '0;
                wl_addr[i] <= '0;
            end
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem[i] <= ERASED;
            end
        end else begin
            done_sy <= {done_sy[1:0], done_tgl};
            if (done_edge) begin
                // Latched bytes reach the array only when the timed cycle ends.
                for (int i = 0; i < 8; i++) begin
                    if (wl_val[i]) begin
                        mem[wl_addr[i]] <= wl_data[i];
                    end
                end
                wl_val <= '0;
                busy   <= 1'b0;
            end
            if (busy) begin
                st     <= D_IDLE;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                st     <= D_IDLE;
                sda_oe <= 1'b0;
                if (wl_val != 8'h0) begin
                    busy     <= 1'b1;
                    req_tgl  <= !req_tgl;
                    long_req <= span && wmode;
                end
            end else if (start_cond) begin
                st     <= D_DEV;
                cnt    <= '0;
                ack_on <= 1'b0;
                sda_oe <= 1'b0;
                wl_val <= '0;
            end else if (scl_rise) begin
                if (rx_state) begin
                    rx  <= byte_in;
                    cnt <= byte_end ? 4'h0 : cnt + 4'h1;
                end
                if (byte_end) begin
                    st <= D_ACK;
                    unique case (st)
                        D_DEV: begin
                            if (!dev_match) begin
                                st <= D_IDLE;
                            end
                            ack_next <= sda_in ? D_RNEXT : D_ADDR;
                        end
                        D_ADDR: begin
                            addr     <= byte_in;
                            base     <= byte_in;
                            span     <= 1'b0;
                            wmode    <= mode_sy[1];
                            ack_next <= D_WDAT;
                        end
                        default: begin
                            wl_data[addr[2:0]] <= byte_in;
                            wl_addr[addr[2:0]] <= addr;
                            wl_val[addr[2:0]]  <= 1'b1;
                            addr               <= next_waddr;
                            if (addr[7:2] != base[7:2]) begin
                                span <= 1'b1;
                            end
                        end
                    endcase
                end else if (st == D_RDAT) begin
                    cnt <= cnt + 4'h1;
                end else if (st == D_RACK) begin
                    st <= sda_in ? D_IDLE : D_RNEXT;
                end
            end else if (load_rd) begin
                sda_oe <= !rd_byte[7];
                tx     <= {rd_byte[6:0], 1'b1};
                addr   <= addr + 8'h1;
                cnt    <= '0;
                ack_on <= 1'b0;
                st     <= D_RDAT;
            end else if (scl_fall) begin
                if (st == D_ACK) begin
                    ack_on <= !ack_on;
                    sda_oe <= !ack_on;
                    if (ack_on) begin
                        st <= ack_next;
                    end
                end else if (st == D_RDAT) begin
                    if (cnt == ACK_BIT) begin
                        sda_oe <= 1'b0;
                        st     <= D_RACK;
                    end else begin
                        sda_oe <= !tx[7];
                        tx     <= {tx[6:0], 1'b1};
                    end
                end
            end
        end
    end

    // Program timer: a toggle starts it, a toggle reports its end.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            req_sy    <= '0;
            long_sy   <= '0;
            prog_busy <= 1'b0;
            done_tgl  <= 1'b0;
            pcnt      <= '0;
        end else begin
            req_sy  <= {req_sy[1:0], req_tgl};
            long_sy <= {long_sy[0], long_req};
            if (req_sy[2] ^ req_sy[1]) begin
                prog_busy <= 1'b1;
                pcnt      <= long_sy[1] ? 24'(PROG_LONG_CYCLES) : 24'(PROG_CYCLES);
            end else if (prog_busy) begin
                pcnt <= pcnt - 24'h1;
                if (pcnt == 24'h1) begin
                    prog_busy <= 1'b0;
                    done_tgl  <= !done_tgl;
                end
            end
        end
    end

endmodule : see_eeprom_dev

`default_nettype wire

// *** tb/see_link_properties.sv ***
`timescale 1ns/100ps
`default_nettype none

module see_link_properties #(
    parameter int unsigned PROG_LONG_CYCLES = 5000000
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic m_sda_out,
    input wire logic m_sda_oe,
    input wire logic d_sda_out,
    input wire logic d_sda_oe,
    input wire logic sda,
    input wire logic prog_busy
);
    logic [31:0] busy_len;

    // Counts the cycles that the program timer has been running.
    always_ff @(posedge core_clk) begin
        if (!rst_n || !prog_busy) begin
            busy_len <= '0;
        end else begin
            busy_len <= busy_len + 32'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_dev_open_drain: assert property (d_sda_oe |-> !d_sda_out)
        else $error("device drives data line high");
    chk_mst_open_drain: assert property (m_sda_oe |-> !m_sda_out)
        else $error("master drives data line high");
    chk_dev_scl_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
        else $error("device data changed while clock high");
    chk_busy_silent: assert property (prog_busy |-> !d_sda_oe)
        else $error("device answered while programming");
    chk_prog_bound: assert property (prog_busy |-> busy_len < PROG_LONG_CYCLES)
        else $error("program cycle too long");
    chk_ack_clock_low: assert property ($rose(d_sda_oe) |-> !scl ##1 (!scl) [*8])
        else $error("device drive began outside clock low");
    chk_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    chk_reset_idle: assert property ($rose(rst_n) |-> scl && !d_sda_oe && !prog_busy)
        else $error("link not idle after reset");

    cover property ($fell(prog_busy));
    cover property ($rose(d_sda_oe));
    cover property (scl && $fell(sda));
endmodule : see_link_properties

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import see_pkg::*;

    typedef struct packed {
        see_op_e    op;
        logic [7:0] data;
        logic       ack;
        logic       exp_ack;
        logic [7:0] exp_data;
    } see_row_s;

    // A faster serial clock keeps the run short; each half stays well above the oversampling.
    localparam int unsigned SIM_QTR = 100;
    localparam int unsigned PROG_N  = 2000;
    // The long cycle must outlast one poll and end before the next one.
    localparam int unsigned PROG_L  = 4200;

    logic       core_clk;
    logic       link_clk;
    logic       rst_n;
    logic       cmd_valid;
    see_op_e    cmd_op;
    logic [7:0] cmd_data;
    logic       cmd_ack;
    logic       cmd_ready;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       rsp_ack;
    logic       prog_busy;
    int         n_fail;
    int         num_checks;
    int         w;
    logic       mode_drive;
    logic       mode_drive_en;
    see_row_s   rows [16];
    see_row_s   r;

    see_link_if link_if ();

    see_bus_master #(.QTR_CYCLES(SIM_QTR)) u_see_bus_master (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .cmd_valid (cmd_valid),
        .cmd_op    (cmd_op),
        .cmd_data  (cmd_data),
        .cmd_ack   (cmd_ack),
        .cmd_ready (cmd_ready),
        .rsp_valid (rsp_valid),
        .rsp_data  (rsp_data),
        .rsp_ack   (rsp_ack),
        .link      (link_if)
    );

    // The mode pin floats until the second reset, then it is driven low for page writes.
    see_eeprom_dev #(.PROG_CYCLES(PROG_N), .PROG_LONG_CYCLES(PROG_L)) u_see_eeprom_dev (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .link_clk      (link_clk),
        .mode_drive    (mode_drive),
        .mode_drive_en (mode_drive_en),
        .prog_busy     (prog_busy),
        .link          (link_if)
    );

    see_link_properties #(.PROG_LONG_CYCLES(PROG_L)) u_see_link_properties (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .scl       (link_if.scl),
        .m_sda_out (link_if.m_sda_out),
        .m_sda_oe  (link_if.m_sda_oe),
        .d_sda_out (link_if.d_sda_out),
        .d_sda_oe  (link_if.d_sda_oe),
        .sda       (link_if.sda),
        .prog_busy (prog_busy)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    task automatic fail(input string msg);
        n_fail++;
        $display("Error %0t: %s", $time, msg);
    endtask : fail

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic run_row(input see_op_e op, input logic [7:0] data, input logic ack);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_data  = data;
        cmd_ack   = ack;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (w = 0; w < 30000 && rsp_valid !== 1'b1; w++) begin
            @(negedge core_clk);
        end
        if (w == 30000) begin
            fail("no answer from master");
            give_verdict();
        end
    endtask : run_row

    // Runs one command and compares the answer in the cycle that rsp_valid stands.
    task automatic check_op(input see_op_e op, input logic [7:0] data, input logic ack,
                            input logic exp_ack, input logic [7:0] exp_data);
        run_row(op, data, ack);
        num_checks++;
        if (rsp_ack !== exp_ack) fail("acknowledge mismatch");
        if (op == OP_WRITE || op == OP_READ) begin
            num_checks++;
            if (rsp_data !== exp_data) fail("data mismatch");
        end
    endtask : check_op

    initial begin
        rst_n         = 1'b0;
        cmd_valid     = 1'b0;
        cmd_op        = OP_START;
        cmd_data      = 8'h00;
        cmd_ack       = 1'b0;
        mode_drive    = 1'b1;
        mode_drive_en = 1'b0;
        n_fail        = 0;
        num_checks    = 0;
        // Multibyte write of 5a and 3c across the top row edge, one poll during the long
        // program cycle, then a random read that wraps from the top address to zero.
        rows = '{
            '{OP_START, 8'h00, 1'b0, 1'b0, 8'h00}, '{OP_WRITE, 8'ha0, 1'b0, 1'b1, 8'ha0},
            '{OP_WRITE, 8'hff, 1'b0, 1'b1, 8'hff}, '{OP_WRITE, 8'h5a, 1'b0, 1'b1, 8'h5a},
            '{OP_WRITE, 8'h3c, 1'b0, 1'b1, 8'h3c}, '{OP_STOP, 8'h00, 1'b0, 1'b0, 8'h00},
            '{OP_START, 8'h00, 1'b0, 1'b0, 8'h00}, '{OP_WRITE, 8'ha0, 1'b0, 1'b0, 8'ha0},
            '{OP_START, 8'h00, 1'b0, 1'b0, 8'h00}, '{OP_WRITE, 8'ha0, 1'b0, 1'b1, 8'ha0},
            '{OP_WRITE, 8'hff, 1'b0, 1'b1, 8'hff}, '{OP_START, 8'h00, 1'b0, 1'b0, 8'h00},
            '{OP_WRITE, 8'ha1, 1'b0, 1'b1, 8'ha1}, '{OP_READ, 8'h00, 1'b1, 1'b1, 8'h5a},
            '{OP_READ, 8'h00, 1'b0, 1'b0, 8'h3c}, '{OP_STOP, 8'h00, 1'b0, 1'b0, 8'h00}};
        // Held longer than 48 cycles so the link side sees four of its own edges.
        repeat (60) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (30) @(negedge core_clk);
        for (int i = 0; i < 16; i++) begin
            r = rows[i];
            check_op(r.op, r.data, r.ack, r.exp_ack, r.exp_data);
            if (i == 7) begin
                num_checks++;
                if (prog_busy !== 1'b1) fail("program timer idle");
            end
        end
        num_checks++;
        if (prog_busy !== 1'b0) fail("program started after read");
        @(negedge core_clk);
        rst_n         = 1'b0;
        mode_drive    = 1'b0;
        mode_drive_en = 1'b1;
        repeat (60) @(negedge core_clk);
        num_checks++;
        if (cmd_ready !== 1'b1 || rsp_valid !== 1'b0 || link_if.scl !== 1'b1) fail("reset state");
        num_checks++;
        if (link_if.d_sda_oe !== 1'b0 || link_if.m_sda_oe !== 1'b0) fail("line driven in reset");
        rst_n = 1'b1;
        repeat (30) @(negedge core_clk);
        // Wrong select code, then a page write of 11 and 22 from the last byte of row 0.
        check_op(OP_START, 8'h00, 1'b0, 1'b0, 8'h00);
        check_op(OP_WRITE, 8'ha2, 1'b0, 1'b0, 8'ha2);
        check_op(OP_START, 8'h00, 1'b0, 1'b0, 8'h00);
        check_op(OP_WRITE, 8'ha0, 1'b0, 1'b1, 8'ha0);
        check_op(OP_WRITE, 8'h07, 1'b0, 1'b1, 8'h07);
        check_op(OP_WRITE, 8'h11, 1'b0, 1'b1, 8'h11);
        check_op(OP_WRITE, 8'h22, 1'b0, 1'b1, 8'h22);
        check_op(OP_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
        num_checks++;
        if (prog_busy !== 1'b1) fail("page program not started");
        for (w = 0; w < PROG_L && prog_busy === 1'b1; w++) begin
            @(negedge core_clk);
        end
        if (w == PROG_L) begin
            fail("program timer stuck");
            give_verdict();
        end
        // Page writes take the short cycle even though the bytes differ in bits 7:2.
        num_checks++;
        if (w <= PROG_N - SIM_QTR || w >= PROG_N) fail("page program length");
        // Random read from the top address: erased by reset, then the wrapped page byte.
        check_op(OP_START, 8'h00, 1'b0, 1'b0, 8'h00);
        check_op(OP_WRITE, 8'ha0, 1'b0, 1'b1, 8'ha0);
        check_op(OP_WRITE, 8'hff, 1'b0, 1'b1, 8'hff);
        check_op(OP_START, 8'h00, 1'b0, 1'b0, 8'h00);
        check_op(OP_WRITE, 8'ha1, 1'b0, 1'b1, 8'ha1);
        check_op(OP_READ, 8'h00, 1'b1, 1'b1, 8'hff);
        check_op(OP_READ, 8'h00, 1'b0, 1'b0, 8'h22);
        check_op(OP_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
        num_checks++;
        if (prog_busy !== 1'b0) fail("program started after page read");
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
